// file: core/ucc_channel.sv
// Host channel characteristics register and transaction launch gate.
//
// Summary of operation
// [RULE1] Periodic transactions start only in the frame parity the odd-frame select names.
// [RULE2] Transactions carry the seven-bit target device address from bits 28:22.
// [RULE3] Software writes reserved bits 21:20 and 16 with their reset value.
// [RULE4] Bits 19:18 pick control, isochronous, bulk or interrupt handling.
// [RULE5] Bit 17 set marks the target as a low-speed device.
// [RULE6] Bit 15 picks endpoint direction: 0 OUT, 1 IN.
// [RULE7] Transactions go to the endpoint number held in bits 14:11.
// [RULE8] Setting the disable request stops the channel processing transactions.
// [RULE9] The disable request sits at bit 30 of the characteristics register.
`timescale 1ns/100ps
`include "ucc_defines.svh"
`default_nettype none
module ucc_channel (
	input  wire logic                    CLK_I,        // 200 MHz host clock
	input  wire logic                    RST_I,        // Async reset, active high
	input  wire logic [`UCC_ADDR_W-1:0]  ADDR_I,       // Register byte address
	input  wire logic [31:0]             WDATA_I,      // Write data
	input  wire logic                    WR_I,         // Write strobe
	input  wire logic                    RD_I,         // Read strobe
	output logic      [31:0]             RDATA_O,      // Read data, cycle after RD_I
	input  wire logic                    XFER_REQ_I,   // Scheduler asks for one transaction
	input  wire logic                    XFER_DONE_I,  // Link engine finished the transaction
	input  wire logic                    FRAME_ODD_I,  // Current frame number is odd
	output logic                         TXN_START_O,  // Transaction launch pulse
	output logic      [6:0]              DEV_ADDR_O,   // Target device address
	output logic      [3:0]              EP_INDEX_O,   // Target endpoint number
	output logic                         EP_DIR_IN_O,  // Endpoint direction is IN
	output ucc_pkg::ucc_ep_type          EP_TYPE_O,    // Endpoint transfer type
	output logic                         LOW_SPEED_O,  // Target is low-speed
	output logic                         PERIODIC_O,   // Transaction is periodic
	output logic                         ACTIVE_O,     // Transaction in flight
	output logic                         HALTED_O      // Channel stopped after disable
);

	logic                   dis_q, dis_d;
	logic                   odd_sel_q, odd_sel_d;
	logic [6:0]             dev_q, dev_d;
	ucc_pkg::ucc_ep_type    type_q, type_d;
	logic                   ls_q, ls_d;
	logic                   dir_q, dir_d;
	logic [3:0]             ep_q, ep_d;
	logic                   halted_q, halted_d;
	logic [31:0]            rdata_q, rdata_d;
	ucc_pkg::ucc_state_type state_q, state_d;
	logic [6:0]             o_dev_q, o_dev_d;
	logic [3:0]             o_ep_q, o_ep_d;
	logic                   o_dir_q, o_dir_d;
	ucc_pkg::ucc_ep_type    o_type_q, o_type_d;
	logic                   o_ls_q, o_ls_d;
	logic                   o_per_q, o_per_d;
	logic                   wr_char, wr_stat, periodic, frame_ok, start;

	assign wr_char  = WR_I && (ADDR_I == `UCC_CHAR_OFS);
	assign wr_stat  = WR_I && (ADDR_I == `UCC_STAT_OFS);
	assign periodic = (type_q == ucc_pkg::UCC_EP_ISO) || (type_q == ucc_pkg::UCC_EP_INTR); // RULE4
	assign frame_ok = !periodic || (FRAME_ODD_I == odd_sel_q); // RULE1
	assign start    = (state_q == ucc_pkg::UCC_WAIT) && frame_ok && !dis_q; // RULE8

	// Register file. Reserved bits are not stored, so they always read back as reset value.
	always_comb begin
		dis_d     = dis_q;
		odd_sel_d = odd_sel_q;
		dev_d     = dev_q;
		type_d    = type_q;
		ls_d      = ls_q;
		dir_d     = dir_q;
		ep_d      = ep_q;
		halted_d  = halted_q;
		rdata_d   = 32'h0000_0000;
		if (wr_char) begin
			dis_d     = WDATA_I[`UCC_DIS_BIT]; // RULE9
			odd_sel_d = WDATA_I[`UCC_ODD_BIT];
			dev_d     = WDATA_I[`UCC_DEV_HI:`UCC_DEV_LO];
			type_d    = ucc_pkg::ucc_ep_type'(WDATA_I[`UCC_TYPE_HI:`UCC_TYPE_LO]);
			ls_d      = WDATA_I[`UCC_LS_BIT];
			dir_d     = WDATA_I[`UCC_DIR_BIT];
			ep_d      = WDATA_I[`UCC_EP_HI:`UCC_EP_LO];
		end
		// Hardware clears the request once the channel is halted, unless software sets it again.
		if (state_q == ucc_pkg::UCC_HALT && !(wr_char && WDATA_I[`UCC_DIS_BIT])) begin
			dis_d = 1'b0;
		end
		if (wr_stat && WDATA_I[`UCC_ST_HALTED]) begin
			halted_d = 1'b0;
		end
		if (state_q == ucc_pkg::UCC_HALT) begin
			halted_d = 1'b1;
		end
		if (RD_I) begin
			if (ADDR_I == `UCC_CHAR_OFS) begin
				rdata_d[`UCC_DIS_BIT]               = dis_q;
				rdata_d[`UCC_ODD_BIT]               = odd_sel_q;
				rdata_d[`UCC_DEV_HI:`UCC_DEV_LO]    = dev_q;
				rdata_d[`UCC_TYPE_HI:`UCC_TYPE_LO]  = type_q;
				rdata_d[`UCC_LS_BIT]                = ls_q;
				rdata_d[`UCC_DIR_BIT]               = dir_q;
				rdata_d[`UCC_EP_HI:`UCC_EP_LO]      = ep_q;
			end else if (ADDR_I == `UCC_STAT_OFS) begin
				rdata_d[`UCC_ST_ACTIVE]  = (state_q == ucc_pkg::UCC_BUSY);
				rdata_d[`UCC_ST_HALTED]  = halted_q;
				rdata_d[`UCC_ST_WAITING] = (state_q == ucc_pkg::UCC_WAIT);
			end
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			dis_q     <= 1'b0;
			odd_sel_q <= 1'b0;
			dev_q     <= `UCC_DEV_RST;
			type_q    <= ucc_pkg::UCC_EP_CONTROL;
			ls_q      <= 1'b0;
			dir_q     <= 1'b0;
			ep_q      <= `UCC_EP_RST;
			halted_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
		end else begin
			dis_q     <= dis_d;
			odd_sel_q <= odd_sel_d;
			dev_q     <= dev_d;
			type_q    <= type_d;
			ls_q      <= ls_d;
			dir_q     <= dir_d;
			ep_q      <= ep_d;
			halted_q  <= halted_d;
			rdata_q   <= rdata_d;
		end
	end

	// Channel sequencing. A transaction already on the wire is allowed to finish before halting,
	// since cutting it short would leave the device mid-handshake.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ucc_pkg::UCC_IDLE: begin
				if (dis_q) begin
					state_d = ucc_pkg::UCC_HALT; // RULE8
				end else if (XFER_REQ_I) begin
					state_d = ucc_pkg::UCC_WAIT;
				end
			end
			ucc_pkg::UCC_WAIT: begin
				if (dis_q) begin
					state_d = ucc_pkg::UCC_HALT; // RULE8
				end else if (start) begin
					state_d = ucc_pkg::UCC_BUSY;
				end
			end
			ucc_pkg::UCC_BUSY: begin
				if (XFER_DONE_I) begin
					state_d = dis_q ? ucc_pkg::UCC_HALT : ucc_pkg::UCC_IDLE; // RULE8
				end
			end
			ucc_pkg::UCC_HALT: begin
				state_d = ucc_pkg::UCC_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_q <= ucc_pkg::UCC_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Descriptor seen by the link engine is frozen at launch, so a rewrite mid-transaction is harmless.
	always_comb begin
		o_dev_d  = o_dev_q;
		o_ep_d   = o_ep_q;
		o_dir_d  = o_dir_q;
		o_type_d = o_type_q;
		o_ls_d   = o_ls_q;
		o_per_d  = o_per_q;
		if (start) begin
			o_dev_d  = dev_q;    // RULE2
			o_ep_d   = ep_q;     // RULE7
			o_dir_d  = dir_q;    // RULE6
			o_type_d = type_q;   // RULE4
			o_ls_d   = ls_q;     // RULE5
			o_per_d  = periodic;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			o_dev_q  <= `UCC_DEV_RST;
			o_ep_q   <= `UCC_EP_RST;
			o_dir_q  <= 1'b0;
			o_type_q <= ucc_pkg::UCC_EP_CONTROL;
			o_ls_q   <= 1'b0;
			o_per_q  <= 1'b0;
		end else begin
			o_dev_q  <= o_dev_d;
			o_ep_q   <= o_ep_d;
			o_dir_q  <= o_dir_d;
			o_type_q <= o_type_d;
			o_ls_q   <= o_ls_d;
			o_per_q  <= o_per_d;
		end
	end

	assign RDATA_O     = rdata_q;
	assign TXN_START_O = start;
	assign DEV_ADDR_O  = o_dev_q;
	assign EP_INDEX_O  = o_ep_q;
	assign EP_DIR_IN_O = o_dir_q;
	assign EP_TYPE_O   = o_type_q;
	assign LOW_SPEED_O = o_ls_q;
	assign PERIODIC_O  = o_per_q;
	assign ACTIVE_O    = (state_q == ucc_pkg::UCC_BUSY);
	assign HALTED_O    = halted_q;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	sequence s_periodic_start;
		start && periodic;
	endsequence
	sequence s_dis_write;
		wr_char && WDATA_I[`UCC_DIS_BIT] && (state_q == ucc_pkg::UCC_IDLE) && !dis_q;
	endsequence
	sequence s_busy_done_disabled;
		(state_q == ucc_pkg::UCC_BUSY) && XFER_DONE_I && dis_q;
	endsequence

	property p_frame_parity;
		s_periodic_start |-> (FRAME_ODD_I == odd_sel_q);
	endproperty
	a_frame_parity: assert property (p_frame_parity) else $error("periodic launch in wrong frame"); // RULE1
	property p_dev_addr;
		start |=> (DEV_ADDR_O == $past(dev_q));
	endproperty
	a_dev_addr: assert property (p_dev_addr) else $error("device address not launched"); // RULE2
	property p_ep_type;
		start |=> (EP_TYPE_O == $past(type_q)) && (PERIODIC_O == EP_TYPE_O[0]);
	endproperty
	a_ep_type: assert property (p_ep_type) else $error("transfer type mismatch"); // RULE4
	property p_low_speed;
		start |=> (LOW_SPEED_O == $past(ls_q)) && ACTIVE_O;
	endproperty
	a_low_speed: assert property (p_low_speed) else $error("low-speed flag not launched"); // RULE5
	property p_direction;
		start |=> (EP_DIR_IN_O == $past(dir_q));
	endproperty
	a_direction: assert property (p_direction) else $error("direction not launched"); // RULE6
	property p_ep_index;
		start |=> (EP_INDEX_O == $past(ep_q));
	endproperty
	a_ep_index: assert property (p_ep_index) else $error("endpoint index not launched"); // RULE7
	property p_busy_halts;
		s_busy_done_disabled |=> (state_q == ucc_pkg::UCC_HALT) ##1 HALTED_O && !ACTIVE_O;
	endproperty
	a_busy_halts: assert property (p_busy_halts) else $error("channel did not halt"); // RULE8
	property p_dis_bit;
		s_dis_write |=> dis_q ##1 (state_q == ucc_pkg::UCC_HALT) && !TXN_START_O;
	endproperty
	a_dis_bit: assert property (p_dis_bit) else $error("bit 30 did not disable"); // RULE9

	// A periodic request parked on the wrong frame must neither launch nor go active.
	sequence s_wrong_frame;
		(state_q == ucc_pkg::UCC_WAIT) && periodic && (FRAME_ODD_I != odd_sel_q);
	endsequence
	sequence s_halt_quiet;
		(state_q == ucc_pkg::UCC_HALT) && !wr_char;
	endsequence

	property p_wrong_frame;
		s_wrong_frame |-> !TXN_START_O ##1 !ACTIVE_O;
	endproperty
	a_wrong_frame: assert property (p_wrong_frame) else $error("launch in wrong frame"); // RULE1
	property p_no_start_disabled;
		dis_q |-> !TXN_START_O;
	endproperty
	a_no_start_disabled: assert property (p_no_start_disabled) else $error("launch while disabled"); // RULE8
	property p_busy_holds;
		((state_q == ucc_pkg::UCC_BUSY) && !XFER_DONE_I) |=> ACTIVE_O;
	endproperty
	a_busy_holds: assert property (p_busy_holds) else $error("transaction cut short"); // RULE8
	property p_halt_rearms;
		s_halt_quiet |=> !dis_q && HALTED_O && (state_q == ucc_pkg::UCC_IDLE);
	endproperty
	a_halt_rearms: assert property (p_halt_rearms) else $error("halt did not re-arm"); // RULE8

	// Field capture: each descriptor field must come from its own bit positions of the written word.
	property p_dev_store;
		wr_char |=> (dev_q == $past(WDATA_I[`UCC_DEV_HI:`UCC_DEV_LO]));
	endproperty
	a_dev_store: assert property (p_dev_store) else $error("device address not stored"); // RULE2
	property p_ep_store;
		wr_char |=> (ep_q == $past(WDATA_I[`UCC_EP_HI:`UCC_EP_LO]));
	endproperty
	a_ep_store: assert property (p_ep_store) else $error("endpoint index not stored"); // RULE7
	property p_dir_store;
		wr_char |=> (dir_q == $past(WDATA_I[`UCC_DIR_BIT]));
	endproperty
	a_dir_store: assert property (p_dir_store) else $error("direction not stored"); // RULE6
	property p_type_store;
		wr_char |=> (type_q == $past(WDATA_I[`UCC_TYPE_HI:`UCC_TYPE_LO]));
	endproperty
	a_type_store: assert property (p_type_store) else $error("transfer type not stored"); // RULE4
	property p_ls_store;
		wr_char |=> (ls_q == $past(WDATA_I[`UCC_LS_BIT]));
	endproperty
	a_ls_store: assert property (p_ls_store) else $error("low-speed flag not stored"); // RULE5

endmodule : ucc_channel
`default_nettype wire

// file: pkg/ucc_defines.svh
// Register offsets, field positions and reset values of the channel characteristics block.
`ifndef UCC_DEFINES_SVH
`define UCC_DEFINES_SVH
`define UCC_ADDR_W       8
`define UCC_CHAR_OFS     8'h00
`define UCC_STAT_OFS     8'h04
`define UCC_DIS_BIT      30
`define UCC_ODD_BIT      29
`define UCC_DEV_HI       28
`define UCC_DEV_LO       22
`define UCC_TYPE_HI      19
`define UCC_TYPE_LO      18
`define UCC_LS_BIT       17
`define UCC_DIR_BIT      15
`define UCC_EP_HI        14
`define UCC_EP_LO        11
`define UCC_ST_ACTIVE    0
`define UCC_ST_HALTED    1
`define UCC_ST_WAITING   2
`define UCC_DEV_RST      7'h00
`define UCC_EP_RST       4'h0
`endif

// file: pkg/ucc_pkg.sv
// Types shared by the channel characteristics block.
package ucc_pkg;
	typedef enum logic [1:0] {
		UCC_EP_CONTROL = 2'h0,
		UCC_EP_ISO     = 2'h1,
		UCC_EP_BULK    = 2'h2,
		UCC_EP_INTR    = 2'h3
	} ucc_ep_type;
	typedef enum logic [1:0] {
		UCC_IDLE,
		UCC_WAIT,
		UCC_BUSY,
		UCC_HALT
	} ucc_state_type;
endpackage : ucc_pkg

// file: sim/ucc_link_model.sv
// Behavioural link engine that finishes each launched transaction after a set delay.
`timescale 1ns/100ps
`default_nettype none
module ucc_link_model (
	input  wire logic       clk_i,   // Host clock
	input  wire logic       rst_i,   // Async reset, active high
	input  wire logic       start_i, // Transaction launch seen
	input  wire logic [2:0] delay_i, // Extra cycles before completion
	output logic            done_o   // Completion pulse
);
	logic [3:0] cnt_q;
	// A delay of zero answers promptly, seven models a slow bus turnaround.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q  <= 4'h0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				cnt_q <= {1'b0, delay_i} + 4'h1;
			end else if (cnt_q == 4'h1) begin
				done_o <= 1'b1;
				cnt_q  <= 4'h0;
			end else if (cnt_q != 4'h0) begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end
endmodule : ucc_link_model
`default_nettype wire

// file: sim/ucc_channel_tb.sv
// Self-checking testbench for the channel characteristics block.
`timescale 1ns/100ps
`default_nettype none
module ucc_channel_tb;
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	logic [7:0]          addr = 8'h00;
	logic [31:0]         wdata = 32'h0;
	logic                wr = 1'b0;
	logic                rd = 1'b0;
	logic                req = 1'b0;
	logic                odd = 1'b0;
	logic [2:0]          dly = 3'h0;
	logic                done, start, dir_in, ls, per, act, halt;
	logic [31:0]         rdata, v, r;
	logic [6:0]          dev;
	logic [3:0]          ep;
	ucc_pkg::ucc_ep_type typ;
	int                  fails = 0;
	int                  cmp_count = 0;
	always #2.5 clk = ~clk;
	ucc_channel i_ucc_channel (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .XFER_REQ_I(req), .XFER_DONE_I(done),
		.FRAME_ODD_I(odd), .TXN_START_O(start), .DEV_ADDR_O(dev), .EP_INDEX_O(ep),
		.EP_DIR_IN_O(dir_in), .EP_TYPE_O(typ), .LOW_SPEED_O(ls), .PERIODIC_O(per),
		.ACTIVE_O(act), .HALTED_O(halt));
	ucc_link_model i_ucc_link_model (.clk_i(clk), .rst_i(rst), .start_i(start),
		.delay_i(dly), .done_o(done));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr32
	task automatic rd32(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd32
	// Reserved bits stay zero, so the readback must equal the written word.
	function automatic logic [31:0] char_word(input logic [1:0] t, input logic s);
		return {2'b00, s, 7'($urandom), 2'b00, t, 1'($urandom), 1'b0, 1'($urandom),
			4'($urandom), 11'h000};
	endfunction : char_word
	task automatic xact(input logic [1:0] t, input logic s);
		int   n;
		logic pe;
		n  = 0;
		pe = t[0];
		v  = char_word(t, s);
		wr32(8'h00, v);
		rd32(8'h00, r);
		chk("char readback", r, v);
		@(posedge clk);
		req <= 1'b1;
		odd <= pe ? ~s : s;
		dly <= 3'($urandom);
		@(posedge clk);
		req <= 1'b0;
		if (pe) begin
			repeat (4) begin
				#1 n += int'(start);
				@(posedge clk);
			end
			chk("wrong frame start", n, 0);
			rd32(8'h04, r);
			chk("status waiting", r, 32'h0000_0004);
			@(posedge clk);
			odd <= s;
			n = 0;
		end
		#1;
		while (start !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		chk("start latency", n, 0);
		@(posedge clk);
		#1 chk("dev addr", 32'(dev), 32'(v[28:22]));
		chk("ep type", 32'(typ), 32'(t));
		chk("periodic", 32'(per), 32'(pe));
		chk("low speed", 32'(ls), 32'(v[17]));
		chk("dir in", 32'(dir_in), 32'(v[15]));
		chk("ep index", 32'(ep), 32'(v[14:11]));
		rd32(8'h04, r);
		chk("status active", r, 32'h0000_0001);
		n = 0;
		while (act === 1'b1 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		chk("active end", 32'(act), 0);
	endtask : xact
	// Disabling mid-transaction lets the transfer run out, then the channel halts and re-arms.
	task automatic busy_disable;
		int n;
		n = 0;
		wr32(8'h00, 32'h0008_0000);
		@(posedge clk);
		req <= 1'b1;
		dly <= 3'h7;
		@(posedge clk);
		req <= 1'b0;
		wr32(8'h00, 32'h4008_0000);
		#1 chk("busy not cut", 32'(act), 1);
		while (act === 1'b1 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		chk("busy length", n, 8);
		repeat (2) @(posedge clk);
		#1 chk("halted after busy", 32'(halt), 1);
		rd32(8'h00, r);
		chk("busy disable cleared", r, 32'h0008_0000);
	endtask : busy_disable
	task automatic results;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	initial begin
		void'($urandom(32'hCD25));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd32(8'h00, r);
		chk("char reset", r, 0);
		rd32(8'h04, r);
		chk("status reset", r, 0);
		wr32(8'h08, 32'hFFFFFFFF);
		rd32(8'h08, r);
		chk("unmapped", r, 0);
		for (int i = 0; i < 24; i++)
			xact(2'(i), 1'(i >> 2));
		wr32(8'h00, 32'h40000000);
		repeat (3) @(posedge clk);
		#1 chk("halted", 32'(halt), 1);
		rd32(8'h00, r);
		chk("disable self-clear", r, 0);
		rd32(8'h04, r);
		chk("status halted", 32'(r[1]), 1);
		wr32(8'h04, 32'h00000002);
		rd32(8'h04, r);
		chk("status cleared", r, 0);
		busy_disable();
		results();
	end
	initial begin
		#20000;
		fails++;
		results();
	end
endmodule : ucc_channel_tb
`default_nettype wire
